// ===== bench/ssarc_ctrl_chk.sv
// Assertion checker for the supervisory control block.
// Assumes a bind onto ssarc_ctrl and the single clk_sys domain.
`timescale 1ns/1ns
module ssarc_ctrl_chk #(
  parameter int unsigned RIDE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Causes
  input wire logic power_ok,
  input wire logic fault_reset,
  input wire logic keypad_enter_key,
  input wire logic lock_request,
  // Effects
  input wire logic undervoltage_trip,
  input wire logic output_hold,
  input wire logic search_active,
  input wire logic volt_raise,
  input wire logic freq_lower,
  input wire logic relay_contact_output,
  input wire logic [3:0] restart_remaining,
  input wire logic restart_disabled,
  input wire logic init_all_pulse,
  input wire logic show_param_code,
  input wire logic param_locked
);
  // ****************
  // Power loss span
  // ****************
  logic [15:0] low_q;
  // Saturates so a long outage cannot wrap back to a short one
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      low_q <= 16'h0000;
    else if (power_ok)
      low_q <= 16'h0000;
    else if (low_q != 16'hFFFF)
      low_q <= low_q + 16'h0001;
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_ride_through: assert property ($rose(undervoltage_trip) |-> low_q >= RIDE_CYCLES - 1)
    else $error("early undervoltage trip");
  a_trip_holds: assert property (undervoltage_trip |-> output_hold)
    else $error("trip without hold");
  a_trip_no_search: assert property (undervoltage_trip |-> !search_active)
    else $error("search during trip");
  a_trip_blocks_restart: assert property ($rose(undervoltage_trip) |-> restart_disabled)
    else $error("restart left enabled");
  a_lower_no_raise: assert property (freq_lower |-> !volt_raise)
    else $error("raise while lowering");
  a_relay_in_search: assert property (relay_contact_output |-> search_active)
    else $error("relay outside search");
  a_count_step: assert property ((restart_remaining < $past(restart_remaining))
    |-> restart_remaining == $past(restart_remaining) - 4'h1)
    else $error("count dropped by over one");
  a_lock_cause: assert property ($changed(param_locked) |-> $past(lock_request))
    else $error("lock change unrequested");
  a_init_cause: assert property (init_all_pulse
    |-> $past(keypad_enter_key) || $past(keypad_enter_key, 2))
    else $error("init without enter");
  a_show_cause: assert property (show_param_code
    |-> $past(keypad_enter_key) || $past(keypad_enter_key, 2))
    else $error("show without enter");
  c_search_lowering: cover property (search_active && freq_lower);
  c_undervoltage: cover property ($rose(undervoltage_trip));
  c_unlock: cover property ($fell(param_locked));
endmodule
bind ssarc_ctrl ssarc_ctrl_chk #(.RIDE_CYCLES(RIDE_CYCLES)) u_chk (.*);

// ===== bench/ssarc_keypad_model.sv
// Keypad operator model: parameter entry, initialise and lock requests.
// Bench calls its tasks; lines change 2 ns after clk_sys rises.
`timescale 1ns/1ns
module ssarc_keypad_model (
  // Clock
  input wire logic clk_sys,
  // Keypad lines
  output logic param_wr,
  output logic [2:0] param_sel,
  output logic [15:0] param_data,
  output logic [1:0] init_group_select,
  output logic keypad_enter_key,
  output logic lock_request,
  output logic [15:0] lock_password
);
  initial
  begin
    {param_wr, keypad_enter_key, lock_request} = 3'h0;
    {param_sel, init_group_select} = 5'h00;
    {param_data, lock_password} = 32'h0000_0000;
  end
  // ****************
  // Operator actions
  // ****************
  // Idle data is inverted so a stale value never passes for a fresh one
  task automatic put(input logic [2:0] sel, input logic [15:0] d);
    @(posedge clk_sys);
    #2;
    {param_sel, param_data, param_wr} = {sel, d, 1'b1};
    @(posedge clk_sys);
    #2;
    {param_data, param_wr} = {~d, 1'b0};
  endtask
  // Lock offered against whatever password the caller passes, right or wrong
  task automatic lock(input logic [15:0] pw);
    @(posedge clk_sys);
    #2;
    {lock_password, lock_request} = {pw, 1'b1};
    @(posedge clk_sys);
    #2;
    {lock_password, lock_request} = {~pw, 1'b0};
  endtask
  task automatic init(input logic [1:0] code);
    @(posedge clk_sys);
    #2;
    {init_group_select, keypad_enter_key} = {code, 1'b1};
    @(posedge clk_sys);
    #2;
    keypad_enter_key = 1'b0;
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the supervisory control block.
// Assumes checker and keypad model; short counts below.
`timescale 1ns/1ns
module testbench;
  logic clk_sys, reset, run_cmd, power_ok, protect_trip, fault_reset, volt_nominal;
  logic emergency_stop_trip, heatsink_overheat, hardware_fault_trip;
  logic clk_en, power_on_start, accel_active;
  logic [15:0] out_freq, resume_freq, param_data, lock_password;
  logic [7:0] current_pct;
  logic [3:0] carrier_eff, restart_remaining;
  logic [2:0] param_sel;
  logic [1:0] init_group_select;
  logic param_wr, keypad_enter_key, lock_request, undervoltage_trip, output_hold;
  logic search_active, volt_raise, freq_lower, relay_contact_output, restart_disabled;
  logic init_all_pulse, init_drive_pulse, init_prog_pulse, show_param_code, param_locked;
  int miscompares, checks_done, n_all, n_drv, n_prg, n_show;
  ssarc_keypad_model kp (.*);
  ssarc_ctrl #(.RIDE_CYCLES(20), .REFILL_CYCLES(100), .TENTH_CYCLES(4)) dut (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Tally pulses; none slips between samples
  always @(posedge clk_sys)
  begin
    n_all += int'(init_all_pulse === 1'b1);
    n_drv += int'(init_drive_pulse === 1'b1);
    n_prg += int'(init_prog_pulse === 1'b1);
    n_show += int'(show_param_code === 1'b1);
  end
  // ****************
  // Helpers
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wait_search();
    for (int i = 0; i < 80 && search_active !== 1'b1; i++) cyc(1);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Whole sequence needs under 2000 cycles
  initial
  begin
    #1_000_000;
    miscompares++;
    end_of_test();
  end
  // ****************
  // Tests
  // ****************
  initial
  begin
    {reset, run_cmd, power_ok, volt_nominal} = 4'hF;
    {protect_trip, fault_reset, emergency_stop_trip, heatsink_overheat} = 4'h0;
    hardware_fault_trip = 1'b0;
    {clk_en, power_on_start, accel_active} = 3'h4;
    out_freq = 16'h1234;
    current_pct = 8'h32;
    cyc(3);
    reset = 1'b0;
    chk(16'(carrier_eff), 16'h0003);
    chk(16'(restart_remaining), 16'h0000);
    $display("test defaults done");
    kp.put(3'h3, 16'h0002);
    kp.put(3'h4, 16'h0001);
    kp.put(3'h2, 16'h000F);
    pulse(fault_reset);
    cyc(1);
    chk(16'(restart_remaining), 16'h0002);
    kp.put(3'h0, 16'h000F);
    volt_nominal = 1'b0;
    pulse(protect_trip);
    wait_search();
    chk(16'(search_active), 16'h0001);
    chk(16'(restart_remaining), 16'h0001);
    cyc(1);
    chk(16'(relay_contact_output), 16'h0001);
    current_pct = 8'h96;
    cyc(3);
    chk(16'({freq_lower, volt_raise}), 16'h0002);
    current_pct = 8'h32;
    cyc(3);
    chk(16'({freq_lower, volt_raise}), 16'h0001);
    {volt_nominal, out_freq} = {1'b1, 16'hFFFF};
    cyc(4);
    chk(16'({search_active, relay_contact_output}), 16'h0000);
    cyc(110);
    chk(16'(restart_remaining), 16'h0002);
    $display("test restart done");
    volt_nominal = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      pulse(protect_trip);
      cyc(3);
      wait_search();
      chk(16'(restart_remaining), 16'(1 - k));
    end
    pulse(protect_trip);
    cyc(60);
    chk(16'(search_active), 16'h0000);
    cyc(120);
    chk(16'(restart_remaining), 16'h0000);
    pulse(fault_reset);
    cyc(1);
    chk(16'(restart_remaining), 16'h0002);
    volt_nominal = 1'b1;
    cyc(10);
    $display("test exhaust done");
    kp.put(3'h5, 16'h0009);
    for (int k = 0; k < 3; k++)
    begin
      {emergency_stop_trip, heatsink_overheat, hardware_fault_trip} = 3'(3'h4 >> k);
      cyc(3);
      if (k == 1) chk(16'(carrier_eff), 16'h0008);
      {emergency_stop_trip, heatsink_overheat, hardware_fault_trip} = 3'h0;
      cyc(30);
      chk(16'(search_active), 16'h0000);
      pulse(fault_reset);
      cyc(10);
    end
    chk(16'(carrier_eff), 16'h0009);
    pulse(power_on_start);
    wait_search();
    chk(16'(search_active), 16'h0001);
    $display("test blocking trips done");
    {out_freq, current_pct, power_ok} = {16'h1234, 8'h96, 1'b0};
    cyc(15);
    power_ok = 1'b1;
    cyc(3);
    chk(16'(undervoltage_trip), 16'h0000);
    power_ok = 1'b0;
    cyc(25);
    chk(16'({undervoltage_trip, output_hold}), 16'h0003);
    {out_freq, power_ok} = {16'h0000, 1'b1};
    wait_search();
    chk(16'({search_active, undervoltage_trip}), 16'h0002);
    chk(resume_freq, 16'h1234);
    {out_freq, current_pct} = {16'hFFFF, 8'h32};
    cyc(5);
    chk(16'(search_active), 16'h0000);
    pulse(fault_reset);
    $display("test power loss done");
    kp.put(3'h6, 16'hA123);
    kp.lock(16'h0BAD);
    cyc(2);
    chk(16'(param_locked), 16'h0000);
    kp.lock(16'hA123);
    cyc(2);
    chk(16'(param_locked), 16'h0001);
    kp.put(3'h5, 16'h0005);
    kp.init(2'h1);
    cyc(3);
    chk(16'(carrier_eff), 16'h0009);
    kp.lock(16'hA123);
    cyc(2);
    chk(16'(param_locked), 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      {n_all, n_drv, n_prg, n_show} = '0;
      kp.init(2'(c));
      cyc(4);
      chk(16'({n_all, n_drv, n_prg} == {32'(c == 1), 32'(c == 2), 32'(c == 3)}), 16'h0001);
      if (c != 0) chk(16'(n_show), 16'h0001);
    end
    chk(16'(carrier_eff), 16'h0003);
    kp.lock(16'hA123);
    cyc(2);
    chk(16'(param_locked), 16'h0001);
    clk_en = 1'b0;
    kp.lock(16'hA123);
    chk(16'(param_locked), 16'h0001);
    clk_en = 1'b1;
    $display("test keypad done");
    end_of_test();
  end
endmodule

// ===== verilog/ssarc_ctrl.sv
// Speed search, ride-through, auto-restart, carrier and lock supervisor.
// Assumes synchronous inputs, one clock, current sensed outside as a percentage.
// Contract
// - Search enable bits: 3 power-on, 2 power-failure restart, 1 fault reset, 0 accel.
// - Search current limit is 80..200 percent of rated current, default 100.
// - Relay function 15 drives relay while speed search is active.
// - Power loss raises undervoltage trip and holds output.
// - On power return resume pre-trip frequency and ramp voltage up.
// - Above limit, stop raising voltage and lower frequency.
// - Below limit, resume raising voltage and stop lowering frequency.
// - Once recovered, end search and continue accelerating from pre-trip frequency.
// - Ride through power loss up to 15 ms without tripping.
// - After trip with run and count nonzero, restart after delay 0..60 s.
// - Each restart decrements remaining count; exhausted count disables restart.
// - Terminal or stop-key reset reloads remaining count from configured tries.
// - Thirty seconds without trip after restart refills remaining count.
// - No auto restart after undervoltage, emergency stop, overheat or hardware trip.
// - Restart after delay accelerates through speed search.
// - Carrier code 0..15, default 3, higher code higher carrier.
// - Heat-sink overheat reduces the carrier frequency.
// - Init code 1 all groups, 2 drive, 3 program, 0 nothing.
// - Enter key confirms init, performs it, returns display to parameter code.
// - Password is a 16-bit value, default 0, used for lock and unlock.
// - Matching password toggles lock; mismatch keeps state; locked blocks writes.
`timescale 1ns/1ns
module ssarc_ctrl #(
  parameter int unsigned RIDE_CYCLES = ssarc_pkg::RIDE_CYC,
  parameter longint unsigned REFILL_CYCLES = ssarc_pkg::REFILL_CYC,
  parameter int unsigned TENTH_CYCLES = ssarc_pkg::TENTH_CYC,
  parameter int unsigned FREQ_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Drive status
  input wire logic run_cmd,
  input wire logic power_ok,
  input wire logic protect_trip,
  input wire logic emergency_stop_trip,
  input wire logic heatsink_overheat,
  input wire logic hardware_fault_trip,
  input wire logic fault_reset,
  input wire logic power_on_start,
  input wire logic accel_active,
  input wire logic [FREQ_W-1:0] out_freq,
  input wire logic [7:0] current_pct,
  input wire logic volt_nominal,
  // Keypad
  input wire logic param_wr,
  input wire logic [2:0] param_sel,
  input wire logic [15:0] param_data,
  input wire logic [1:0] init_group_select,
  input wire logic keypad_enter_key,
  input wire logic lock_request,
  input wire logic [15:0] lock_password,
  // Drive commands
  output logic undervoltage_trip,
  output logic output_hold,
  output logic search_active,
  output logic volt_raise,
  output logic freq_lower,
  output logic [FREQ_W-1:0] resume_freq,
  output logic relay_contact_output,
  output logic [3:0] carrier_eff,
  output logic [3:0] restart_remaining,
  output logic restart_disabled,
  output logic init_all_pulse,
  output logic init_drive_pulse,
  output logic init_prog_pulse,
  output logic show_param_code,
  output logic param_locked
);

  // ************************************************
  // Parameters
  // ************************************************
  logic [3:0] srch_en;
  logic [7:0] srch_lim;
  logic [4:0] relay_fn;
  logic [3:0] tries;
  logic [9:0] delay_tenths;
  logic [3:0] carrier;
  logic [15:0] password;
  logic init_drive_s;
  logic init_prog_s;

  assign init_drive_s = init_all_pulse | init_drive_pulse;
  assign init_prog_s = init_all_pulse | init_prog_pulse;

  ssarc_param_store u_store (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(param_wr & ~param_locked),
    .wr_sel(param_sel),
    .wr_data(param_data),
    .init_drive(init_drive_s),
    .init_prog(init_prog_s),
    .search_enable_bits(srch_en),
    .search_current_limit(srch_lim),
    .relay_function_select(relay_fn),
    .restart_try_count(tries),
    .restart_delay(delay_tenths),
    .carrier_select(carrier),
    .password_store(password)
  );

  // ************************************************
  // Ride-through and trips
  // ************************************************
  ssarc_pkg::ssarc_state_e state_q;
  logic [31:0] ride_q;
  logic ride_expired;
  logic blocking_trip;
  logic any_trip;
  logic over_limit;

  assign ride_expired = ride_q >= RIDE_CYCLES;
  assign blocking_trip = emergency_stop_trip | heatsink_overheat | hardware_fault_trip;
  assign over_limit = current_pct > srch_lim;

  // Power loss counted; only a loss longer than the ride-through trips
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      ride_q <= '0;
    else if (clk_en)
    begin
      if (power_ok)
        ride_q <= '0;
      else if (!ride_expired)
        ride_q <= ride_q + 32'd1;
    end
  end

  assign any_trip = (!power_ok && ride_expired && !undervoltage_trip) | protect_trip | blocking_trip;

  // ************************************************
  // Timers
  // ************************************************
  logic delay_start;
  logic delay_busy;
  logic delay_done;
  logic refill_start;
  logic refill_done;
  logic refill_busy;
  logic [31:0] tenth_q;
  logic [9:0] tenths_q;
  logic tenth_tick;

  assign tenth_tick = tenth_q >= TENTH_CYCLES - 1;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      tenth_q <= '0;
      tenths_q <= '0;
    end
    else if (clk_en)
    begin
      if (delay_start || state_q != ssarc_pkg::SSARC_DELAY)
      begin
        tenth_q <= '0;
        tenths_q <= '0;
      end
      else if (tenth_tick)
      begin
        tenth_q <= '0;
        tenths_q <= tenths_q + 10'd1;
      end
      else
        tenth_q <= tenth_q + 32'd1;
    end
  end

  assign delay_busy = state_q == ssarc_pkg::SSARC_DELAY;
  assign delay_done = delay_busy && tenths_q >= delay_tenths;

  ssarc_timer #(.WIDTH(64)) u_refill (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .start(refill_start),
    .stop(any_trip),
    .load_val(REFILL_CYCLES),
    .busy(refill_busy),
    .done(refill_done)
  );

  // ************************************************
  // Sequence
  // ************************************************
  logic search_req;
  assign search_req = (power_on_start && srch_en[ssarc_pkg::SRCH_BIT_PWRON])
    || (fault_reset && srch_en[ssarc_pkg::SRCH_BIT_RESET])
    || (accel_active && srch_en[ssarc_pkg::SRCH_BIT_ACCEL]);

  assign delay_start = state_q == ssarc_pkg::SSARC_TRIPPED && run_cmd
    && !restart_disabled && restart_remaining != 4'h0;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ssarc_pkg::SSARC_RUN;
      undervoltage_trip <= 1'b0;
      output_hold <= 1'b0;
      resume_freq <= '0;
      refill_start <= 1'b0;
    end
    else if (clk_en)
    begin
      refill_start <= 1'b0;
      case (state_q)
        ssarc_pkg::SSARC_RUN:
        begin
          if (!power_ok && ride_expired)
          begin
            state_q <= ssarc_pkg::SSARC_HOLD;
            undervoltage_trip <= 1'b1;
            output_hold <= 1'b1;
            resume_freq <= out_freq;
          end
          else if (protect_trip || blocking_trip)
          begin
            state_q <= ssarc_pkg::SSARC_TRIPPED;
            output_hold <= 1'b1;
            resume_freq <= out_freq;
          end
          else if (search_req)
            state_q <= ssarc_pkg::SSARC_SEARCH;
        end
        ssarc_pkg::SSARC_HOLD:
        begin
          if (power_ok)
          begin
            undervoltage_trip <= 1'b0;
            output_hold <= 1'b0;
            state_q <= srch_en[ssarc_pkg::SRCH_BIT_IPF] ? ssarc_pkg::SSARC_SEARCH
                                                        : ssarc_pkg::SSARC_RUN;
          end
        end
        ssarc_pkg::SSARC_TRIPPED:
        begin
          if (fault_reset)
          begin
            output_hold <= 1'b0;
            state_q <= srch_en[ssarc_pkg::SRCH_BIT_RESET] ? ssarc_pkg::SSARC_SEARCH
                                                          : ssarc_pkg::SSARC_RUN;
          end
          else if (delay_start)
            state_q <= ssarc_pkg::SSARC_DELAY;
        end
        ssarc_pkg::SSARC_DELAY:
        begin
          if (any_trip || !run_cmd)
            state_q <= ssarc_pkg::SSARC_TRIPPED;
          else if (delay_done)
          begin
            output_hold <= 1'b0;
            refill_start <= 1'b1;
            state_q <= ssarc_pkg::SSARC_SEARCH;
          end
        end
        ssarc_pkg::SSARC_SEARCH:
        begin
          if (!power_ok && ride_expired)
          begin
            state_q <= ssarc_pkg::SSARC_HOLD;
            undervoltage_trip <= 1'b1;
            output_hold <= 1'b1;
          end
          else if (protect_trip || blocking_trip)
          begin
            state_q <= ssarc_pkg::SSARC_TRIPPED;
            output_hold <= 1'b1;
          end
          else if (volt_nominal && !over_limit && out_freq >= resume_freq)
            state_q <= ssarc_pkg::SSARC_RUN;
        end
        default: state_q <= ssarc_pkg::SSARC_RUN;
      endcase
    end
  end

  // Search loop commands
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      search_active <= 1'b0;
      volt_raise <= 1'b0;
      freq_lower <= 1'b0;
      relay_contact_output <= 1'b0;
    end
    else if (clk_en)
    begin
      search_active <= state_q == ssarc_pkg::SSARC_SEARCH;
      volt_raise <= state_q == ssarc_pkg::SSARC_SEARCH && !over_limit && !volt_nominal;
      freq_lower <= state_q == ssarc_pkg::SSARC_SEARCH && over_limit;
      relay_contact_output <= state_q == ssarc_pkg::SSARC_SEARCH
        && relay_fn == ssarc_pkg::RELAY_SRCH_CODE;
    end
  end

  // ************************************************
  // Restart count
  // ************************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      restart_remaining <= ssarc_pkg::TRY_RST;
      restart_disabled <= 1'b0;
    end
    else if (clk_en)
    begin
      if (fault_reset)
      begin
        restart_remaining <= tries;
        restart_disabled <= 1'b0;
      end
      else if (any_trip && (blocking_trip || (!power_ok && ride_expired)))
        restart_disabled <= 1'b1;
      else if (delay_done && state_q == ssarc_pkg::SSARC_DELAY && !any_trip && run_cmd)
        restart_remaining <= restart_remaining - 4'h1;
      else if (refill_done && !any_trip)
        restart_remaining <= tries;
      else if (state_q == ssarc_pkg::SSARC_TRIPPED && restart_remaining == 4'h0)
        restart_disabled <= 1'b1;
    end
  end

  // ************************************************
  // Carrier, initialise and lock
  // ************************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      carrier_eff <= ssarc_pkg::CARRIER_RST;
    else if (clk_en)
      carrier_eff <= (heatsink_overheat && carrier != 4'h0) ? carrier - 4'h1 : carrier;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      init_all_pulse <= 1'b0;
      init_drive_pulse <= 1'b0;
      init_prog_pulse <= 1'b0;
      show_param_code <= 1'b0;
    end
    else if (clk_en)
    begin
      // Blocked while locked so an init cannot bypass the lock
      init_all_pulse <= keypad_enter_key && !param_locked
        && init_group_select == ssarc_pkg::INIT_ALL;
      init_drive_pulse <= keypad_enter_key && !param_locked
        && init_group_select == ssarc_pkg::INIT_DRIVE;
      init_prog_pulse <= keypad_enter_key && !param_locked
        && init_group_select == ssarc_pkg::INIT_PROG;
      show_param_code <= keypad_enter_key;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      param_locked <= 1'b0;
    else if (clk_en && lock_request && lock_password == password)
      param_locked <= ~param_locked;
  end

endmodule

// ===== verilog/ssarc_param_store.sv
// Parameter store for the keypad-set settings of the supervisory block.
// Assumes writes arrive as single-cycle strobes already validated.
`timescale 1ns/1ns
module ssarc_param_store (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  // Group initialise
  input wire logic init_drive,
  input wire logic init_prog,
  // Registered read data
  output logic [3:0] search_enable_bits,
  output logic [7:0] search_current_limit,
  output logic [4:0] relay_function_select,
  output logic [3:0] restart_try_count,
  output logic [9:0] restart_delay,
  output logic [3:0] carrier_select,
  output logic [15:0] password_store
);

  // Field selectors on the write port
  localparam logic [2:0] SEL_SRCH = 3'h0;
  localparam logic [2:0] SEL_LIM = 3'h1;
  localparam logic [2:0] SEL_RELAY = 3'h2;
  localparam logic [2:0] SEL_TRY = 3'h3;
  localparam logic [2:0] SEL_DELAY = 3'h4;
  localparam logic [2:0] SEL_CARR = 3'h5;
  localparam logic [2:0] SEL_PASS = 3'h6;

  // Program group; password survives init
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      search_enable_bits <= ssarc_pkg::SRCH_EN_RST;
      search_current_limit <= ssarc_pkg::SRCH_LIM_RST;
      relay_function_select <= ssarc_pkg::RELAY_FN_RST;
      restart_try_count <= ssarc_pkg::TRY_RST;
      restart_delay <= ssarc_pkg::DELAY_RST;
      carrier_select <= ssarc_pkg::CARRIER_RST;
      password_store <= ssarc_pkg::PASSWORD_RST;
    end
    else if (clk_en)
    begin
      if (init_prog)
      begin
        search_enable_bits <= ssarc_pkg::SRCH_EN_RST;
        search_current_limit <= ssarc_pkg::SRCH_LIM_RST;
        relay_function_select <= ssarc_pkg::RELAY_FN_RST;
        restart_try_count <= ssarc_pkg::TRY_RST;
        restart_delay <= ssarc_pkg::DELAY_RST;
        carrier_select <= ssarc_pkg::CARRIER_RST;
      end
      else if (wr_en)
      begin
        case (wr_sel)
          SEL_SRCH: search_enable_bits <= wr_data[3:0];
          SEL_LIM:
          begin
            if (wr_data[7:0] >= ssarc_pkg::SRCH_LIM_MIN && wr_data[7:0] <= ssarc_pkg::SRCH_LIM_MAX)
              search_current_limit <= wr_data[7:0];
          end
          SEL_RELAY: relay_function_select <= wr_data[4:0];
          SEL_TRY:
          begin
            if (wr_data[3:0] <= ssarc_pkg::TRY_MAX)
              restart_try_count <= wr_data[3:0];
          end
          SEL_DELAY:
          begin
            if (wr_data[9:0] <= ssarc_pkg::DELAY_MAX)
              restart_delay <= wr_data[9:0];
          end
          SEL_CARR: carrier_select <= wr_data[3:0];
          SEL_PASS: password_store <= wr_data;
          default: ;
        endcase
      end
    end
  end

endmodule

// ===== verilog/ssarc_pkg.sv
// Constants shared by the supervisory control block.
// Assumes a 10 MHz system clock.
package ssarc_pkg;

  // ************************************************
  // Timing
  // ************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RIDE_MS = 15;
  localparam int unsigned RIDE_CYC = RIDE_MS * (CLK_HZ / 1000);
  localparam int unsigned REFILL_S = 30;
  localparam longint unsigned REFILL_CYC = longint'(REFILL_S) * CLK_HZ;
  localparam int unsigned TENTH_S_MS = 100;
  localparam int unsigned TENTH_CYC = TENTH_S_MS * (CLK_HZ / 1000);

  // ************************************************
  // Parameter fields and defaults
  // ************************************************
  localparam int unsigned SRCH_BIT_PWRON = 3;
  localparam int unsigned SRCH_BIT_IPF = 2;
  localparam int unsigned SRCH_BIT_RESET = 1;
  localparam int unsigned SRCH_BIT_ACCEL = 0;
  localparam logic [3:0] SRCH_EN_RST = 4'h0;
  localparam logic [7:0] SRCH_LIM_MIN = 8'h50;
  localparam logic [7:0] SRCH_LIM_MAX = 8'hC8;
  localparam logic [7:0] SRCH_LIM_RST = 8'h64;
  localparam logic [4:0] RELAY_SRCH_CODE = 5'h0F;
  localparam logic [4:0] RELAY_FN_RST = 5'h11;
  localparam logic [3:0] TRY_MAX = 4'hA;
  localparam logic [3:0] TRY_RST = 4'h0;
  localparam logic [9:0] DELAY_MAX = 10'h258;
  localparam logic [9:0] DELAY_RST = 10'h00A;
  localparam logic [3:0] CARRIER_RST = 4'h3;
  localparam logic [15:0] PASSWORD_RST = 16'h0000;

  // ************************************************
  // Initialise codes
  // ************************************************
  localparam logic [1:0] INIT_NONE = 2'h0;
  localparam logic [1:0] INIT_ALL = 2'h1;
  localparam logic [1:0] INIT_DRIVE = 2'h2;
  localparam logic [1:0] INIT_PROG = 2'h3;

  typedef enum logic [2:0] {
    SSARC_RUN,
    SSARC_HOLD,
    SSARC_TRIPPED,
    SSARC_DELAY,
    SSARC_SEARCH
  } ssarc_state_e;

endpackage

// ===== verilog/ssarc_timer.sv
// Down-counting one-shot timer with a done pulse.
// Assumes start and stop are synchronous single-cycle strobes.
`timescale 1ns/1ns
module ssarc_timer #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] load_val,
  // Status
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] cnt_q;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_q <= load_val;
        busy <= 1'b1;
      end
      else if (stop)
        busy <= 1'b0;
      else if (busy)
      begin
        if (cnt_q <= WIDTH'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt_q <= cnt_q - WIDTH'(1);
      end
    end
  end

endmodule
